// file: rtl/qdst_pkg.sv
package qdst_pkg;

    localparam int QDST_QUADS = 8;

    typedef enum logic [1:0]
    {
        QDST_MODE_IMMEDIATE,
        QDST_MODE_MANUAL,
        QDST_MODE_TIMED,
        QDST_MODE_FIFO
    } qdst_mode_t;

    typedef struct packed
    {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } qdst_bus_req_t;

    typedef struct packed
    {
        logic [QDST_QUADS-1:0] xfer_active;
        logic [QDST_QUADS-1:0] load_pending;
        logic [QDST_QUADS-1:0] seq_fetch;
        logic [QDST_QUADS-1:0] seq_request;
        logic [QDST_QUADS-1:0] output_update;
    } qdst_events_t;

endpackage : qdst_pkg

// file: rtl/qdst_regs.svh
`ifndef QDST_REGS_SVH
`define QDST_REGS_SVH

// Register byte addresses
`define QDST_STATUS_ADDR      12'h08c
`define QDST_IRQ_STATUS_ADDR  12'h090
`define QDST_IRQ_ENABLE_ADDR  12'h094
`define QDST_IRQ_CLEAR_ADDR   12'h098
`define QDST_CONTROL_ADDR     12'h09c

// Field positions within a quad's nibble
`define QDST_BIT_BUSY         0
`define QDST_BIT_SETTLE       1
`define QDST_BIT_REQUEST      2
`define QDST_BIT_UNDERFLOW    3

// Reset values
`define QDST_STATUS_RESET     32'h0000_0000
`define QDST_ZERO_WORD        32'h0000_0000

// Settle time in ns and clock period in ns
`define QDST_SETTLE_NS        10000
`define QDST_CLOCK_NS         5
`define QDST_SETTLE_CYCLES    (`QDST_SETTLE_NS / `QDST_CLOCK_NS)

`endif

// file: rtl/qdst_status_tracker.sv
`timescale 1ns/1ps
`include "qdst_regs.svh"
module qdst_status_tracker
    import qdst_pkg::*;
#(
    parameter int QUADS         = 8,
    parameter int SETTLE_CYCLES = `QDST_SETTLE_CYCLES
)
(
    input  wire logic              i_clock,
    input  wire logic              i_arst_n,
    input  wire logic [11:0]       i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    input  wire logic [2*QUADS-1:0] i_mode,
    input  wire logic [QUADS-1:0]  i_seq_running,
    input  wire logic [QUADS-1:0]  i_xfer_active,
    input  wire logic [QUADS-1:0]  i_load_pending,
    input  wire logic [QUADS-1:0]  i_seq_fetch,
    input  wire logic [QUADS-1:0]  i_seq_request,
    input  wire logic [QUADS-1:0]  i_output_update,
    output logic      [QUADS-1:0]  o_sequencer_run_bit,
    output logic      [QUADS-1:0]  o_busy,
    output logic                   o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus request bundle and event bundle

    qdst_bus_req_t                 bus;
    qdst_events_t                  ev;
    logic          [QUADS-1:0]     timed_mode;

    assign bus.addr  = i_addr;
    assign bus.wdata = i_wdata;
    assign bus.wr    = i_wr;
    assign bus.rd    = i_rd;

    assign ev.xfer_active   = i_xfer_active;
    assign ev.load_pending  = i_load_pending;
    assign ev.seq_fetch     = i_seq_fetch;
    assign ev.seq_request   = i_seq_request;
    assign ev.output_update = i_output_update;

    function automatic logic wr_hit(input qdst_bus_req_t b, input logic [11:0] a);
        wr_hit = b.wr && (b.addr == a);
    endfunction : wr_hit

    // Only timed mode drives the request/underflow handshake
    always_comb
    begin
        for (int q = 0; q < QUADS; q++)
        begin
            timed_mode[q] = (qdst_mode_t'(i_mode[2*q +: 2]) == QDST_MODE_TIMED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky request and underflow flags

    logic             status_wr;
    logic [QUADS-1:0] request_reg;
    logic [QUADS-1:0] request_set;
    logic [QUADS-1:0] request_clr;
    logic [QUADS-1:0] request_next;
    logic [QUADS-1:0] underflow_reg;
    logic [QUADS-1:0] underflow_set;
    logic [QUADS-1:0] underflow_clr;
    logic [QUADS-1:0] underflow_next;

    // One rule for every sticky bit: an event in the clear cycle survives
    function automatic logic [QUADS-1:0] sticky_next
    (
        input logic [QUADS-1:0] cur,
        input logic [QUADS-1:0] clr,
        input logic [QUADS-1:0] set
    );
        sticky_next = (cur & ~clr) | set;
    endfunction : sticky_next

    assign status_wr = wr_hit(bus, `QDST_STATUS_ADDR);

    // Zero bits and the settle and busy positions are never looked at
    always_comb
    begin
        for (int q = 0; q < QUADS; q++)
        begin
            request_clr[q]   = status_wr && bus.wdata[4*q + `QDST_BIT_REQUEST];
            underflow_clr[q] = status_wr && bus.wdata[4*q + `QDST_BIT_UNDERFLOW];
        end
    end

    // Fetch without a pending request is the normal, quiet case
    assign request_set    = ev.seq_request & timed_mode;
    assign underflow_set  = ev.seq_fetch & request_reg & timed_mode;
    assign request_next   = sticky_next(request_reg, request_clr, request_set);
    assign underflow_next = sticky_next(underflow_reg, underflow_clr, underflow_set);

    // Flags only inform; nothing here feeds back to stall the sequencer
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            request_reg <= '0;
        end
        else
        begin
            request_reg <= request_next;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            underflow_reg <= '0;
        end
        else
        begin
            // Fetch proceeds with direct-space data regardless
            underflow_reg <= underflow_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settle timers

    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);

    logic [QUADS-1:0][SETTLE_W-1:0] settle_cnt_reg;
    logic [QUADS-1:0]               settle_reg;

    // Loaded with the full count so the flag stands exactly SETTLE_CYCLES cycles
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            settle_cnt_reg <= '0;
        end
        else
        begin
            for (int q = 0; q < QUADS; q++)
            begin
                if (ev.output_update[q])
                begin
                    settle_cnt_reg[q] <= SETTLE_W'(SETTLE_CYCLES);
                end
                else if (settle_cnt_reg[q] != '0)
                begin
                    settle_cnt_reg[q] <= settle_cnt_reg[q] - 1'b1;
                end
            end
        end
    end

    // A new update restarts the window, so back-to-back updates keep it high
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            settle_reg <= '0;
        end
        else
        begin
            for (int q = 0; q < QUADS; q++)
            begin
                if (ev.output_update[q])
                begin
                    settle_reg[q] <= 1'b1;
                end
                else if (settle_cnt_reg[q] <= SETTLE_W'(1))
                begin
                    settle_reg[q] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Busy: transfer, pending manual load or running sequencer

    logic [QUADS-1:0] busy_reg;

    // Registered for a clean output; it trails the engine's levels by one cycle
    // Data writes are not blocked by busy; the transfer engine queues them
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            busy_reg <= '0;
        end
        else
        begin
            busy_reg <= ev.xfer_active | ev.load_pending | i_seq_running;
        end
    end

    assign o_busy = busy_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer run bits and control

    logic [QUADS-1:0] run_reg;

    // Stopping only drops the bit; the sequencer finishes its transfer
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            run_reg <= '0;
        end
        else if (wr_hit(bus, `QDST_CONTROL_ADDR))
        begin
            run_reg <= bus.wdata[QUADS-1:0];
        end
    end

    assign o_sequencer_run_bit = run_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer interrupt status, enable, clear

    logic [QUADS-1:0] irq_status_reg;
    logic [QUADS-1:0] irq_status_next;
    logic [QUADS-1:0] irq_enable_reg;
    logic [QUADS-1:0] irq_set;
    logic [QUADS-1:0] irq_clr;
    logic             irq_reg;

    assign irq_clr = wr_hit(bus, `QDST_IRQ_CLEAR_ADDR) ? bus.wdata[QUADS-1:0] : '0;

    // A disabled quad logs nothing, so a later enable cannot fire a stale event
    assign irq_set         = ev.seq_request & irq_enable_reg;
    assign irq_status_next = sticky_next(irq_status_reg, irq_clr, irq_set);

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            irq_enable_reg <= '0;
        end
        else if (wr_hit(bus, `QDST_IRQ_ENABLE_ADDR))
        begin
            irq_enable_reg <= bus.wdata[QUADS-1:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            irq_status_reg <= '0;
        end
        else
        begin
            irq_status_reg <= irq_status_next;
        end
    end

    // Registered so the output comes straight from a flop
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(irq_status_next & irq_enable_reg);
        end
    end

    assign o_irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Status word assembly and read port

    logic [31:0] status_word;
    logic [31:0] rdata_reg;

    always_comb
    begin
        status_word = `QDST_STATUS_RESET;
        for (int q = 0; q < QUADS; q++)
        begin
            status_word[4*q + `QDST_BIT_UNDERFLOW] = underflow_reg[q];
            status_word[4*q + `QDST_BIT_REQUEST]   = request_reg[q];
            status_word[4*q + `QDST_BIT_SETTLE]    = settle_reg[q];
            status_word[4*q + `QDST_BIT_BUSY]      = busy_reg[q];
        end
    end

    // Quad-wide registers sit in the low bits; the rest read as zero
    function automatic logic [31:0] pad_quads(input logic [QUADS-1:0] bits);
        pad_quads = {{(32-QUADS){1'b0}}, bits};
    endfunction : pad_quads

    // Unmapped addresses read as zero
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rdata_reg <= `QDST_ZERO_WORD;
        end
        else if (bus.rd)
        begin
            case (bus.addr)
                `QDST_STATUS_ADDR:     rdata_reg <= status_word;
                `QDST_IRQ_STATUS_ADDR: rdata_reg <= pad_quads(irq_status_reg);
                `QDST_IRQ_ENABLE_ADDR: rdata_reg <= pad_quads(irq_enable_reg);
                `QDST_CONTROL_ADDR:    rdata_reg <= pad_quads(run_reg);
                default:               rdata_reg <= `QDST_ZERO_WORD;
            endcase
        end
        else
        begin
            rdata_reg <= `QDST_ZERO_WORD;
        end
    end

    assign o_rdata = rdata_reg;

endmodule : qdst_status_tracker

// file: test/qdst_engine_model.sv
`timescale 1ns/1ps
module qdst_engine_model
    import qdst_pkg::*;
(
    input  wire logic [QDST_QUADS-1:0] i_run,
    input  wire logic                  i_clock,
    output qdst_events_t               o_ev,
    output logic [QDST_QUADS-1:0]      o_running
);
    initial o_ev = '0;
    initial o_running = '0;
    // Sequencer ignores flags; only its run bit moves it
    always @(posedge i_clock) o_running <= i_run;
    // Requests come in every mode; fifo handshake needs no host
    task automatic pulse(input int k, input logic [7:0] m);
        @(posedge i_clock);
        case (k)
            0: o_ev.seq_request <= m;
            1: o_ev.seq_fetch <= m;
            default: o_ev.output_update <= m;
        endcase
        @(posedge i_clock);
        case (k)
            0: o_ev.seq_request <= '0;
            1: o_ev.seq_fetch <= '0;
            default: o_ev.output_update <= '0;
        endcase
    endtask : pulse
    // Transfers run to their end whatever the run bits do
    task automatic level(input logic [7:0] x, input logic [7:0] l);
        @(posedge i_clock);
        o_ev.xfer_active <= x;
        o_ev.load_pending <= l;
    endtask : level
endmodule : qdst_engine_model

// file: test/qdst_status_tracker_sva.sv
`timescale 1ns/1ps
`include "qdst_regs.svh"
module qdst_status_tracker_sva
    import qdst_pkg::*;
#(
    parameter int QUADS         = 8,
    parameter int SETTLE_CYCLES = `QDST_SETTLE_CYCLES
)
(
    input wire logic               i_clock,
    input wire logic               i_arst_n,
    input wire logic [11:0]        i_addr,
    input wire logic [31:0]        i_wdata,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire logic [31:0]        o_rdata,
    input wire logic [2*QUADS-1:0] i_mode,
    input wire logic [QUADS-1:0]   i_seq_running,
    input wire logic [QUADS-1:0]   i_xfer_active,
    input wire logic [QUADS-1:0]   i_load_pending,
    input wire logic [QUADS-1:0]   i_seq_fetch,
    input wire logic [QUADS-1:0]   i_seq_request,
    input wire logic [QUADS-1:0]   i_output_update,
    input wire logic [QUADS-1:0]   o_sequencer_run_bit,
    input wire logic [QUADS-1:0]   o_busy,
    input wire logic               o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////
    sequence s_req; i_mode[1:0] == QDST_MODE_TIMED && i_seq_request[0]; endsequence
    sequence s_rd; i_rd && i_addr == `QDST_STATUS_ADDR; endsequence
    sequence s_fetch; i_mode[1:0] == QDST_MODE_TIMED && i_seq_fetch[0] && !i_wr; endsequence
    property p_req; s_req ##1 !i_wr ##1 s_rd |=> o_rdata[2]; endproperty
    property p_under; s_req ##1 s_fetch ##1 s_rd |=> o_rdata[3]; endproperty
    property p_settle; i_output_update[0] ##1 s_rd |=> o_rdata[1]; endproperty
    property p_xfer;
        |i_xfer_active |=> (o_busy & $past(i_xfer_active)) == $past(i_xfer_active);
    endproperty
    property p_hold;
        |(i_load_pending | i_seq_running) |=> &(o_busy | ~$past(i_load_pending | i_seq_running));
    endproperty
    // Busy may only follow a real cause, never linger
    property p_idle; 1'b1 |=> (o_busy & ~$past(i_xfer_active | i_load_pending | i_seq_running)) == '0;
    endproperty
    property p_run; !(i_wr && i_addr == `QDST_CONTROL_ADDR) |=> $stable(o_sequencer_run_bit);
    endproperty
    property p_irq; $rose(o_irq) |-> $past(|i_seq_request) || $past(i_wr); endproperty
    a_req: assert property (p_req) else $error("request flag not set");
    a_under: assert property (p_under) else $error("underflow flag not set");
    a_settle: assert property (p_settle) else $error("settle not set");
    a_xfer: assert property (p_xfer) else $error("busy missing on transfer");
    a_hold: assert property (p_hold) else $error("busy missing on load or run");
    a_idle: assert property (p_idle) else $error("busy without cause");
    a_run: assert property (p_run) else $error("run bits changed alone");
    a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule : qdst_status_tracker_sva

bind qdst_status_tracker qdst_status_tracker_sva #(.QUADS(QUADS), .SETTLE_CYCLES(SETTLE_CYCLES))
    u_sva (.*);

// file: test/qdst_status_tracker_tb.sv
`timescale 1ns/1ps
`include "qdst_regs.svh"
module qdst_status_tracker_tb
    import qdst_pkg::*;
;
    logic         i_clock  = 1'b0;
    logic         i_arst_n = 1'b0;
    logic         i_wr     = 1'b0;
    logic         i_rd     = 1'b0;
    logic [11:0]  i_addr   = '0;
    logic [31:0]  i_wdata  = '0;
    logic [15:0]  i_mode   = '0;
    logic [31:0]  o_rdata;
    logic [7:0]   run_bits;
    logic [7:0]   busy;
    logic [7:0]   running;
    logic         o_irq;
    qdst_events_t ev;
    int           failures = 0;
    int           samples_checked = 0;
    localparam int SETTLE = 8;
    always #2.5 i_clock = ~i_clock;
    qdst_engine_model ENG (.i_run(run_bits), .i_clock(i_clock), .o_ev(ev), .o_running(running));
    qdst_status_tracker #(.SETTLE_CYCLES(SETTLE)) DUT (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mode(i_mode),
        .i_seq_running(running), .i_xfer_active(ev.xfer_active),
        .i_load_pending(ev.load_pending), .i_seq_fetch(ev.seq_fetch),
        .i_seq_request(ev.seq_request), .i_output_update(ev.output_update),
        .o_sequencer_run_bit(run_bits), .o_busy(busy), .o_irq(o_irq));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(exp, o_rdata);
    endtask : rd
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge i_clock);
        i_arst_n <= 1'b1;
        rd(`QDST_STATUS_ADDR, 32'h0);
        rd(`QDST_IRQ_STATUS_ADDR, 32'h0);
        rd(12'h0f0, 32'h0);
        wr(`QDST_CONTROL_ADDR, 32'ha5);
        rd(`QDST_CONTROL_ADDR, 32'ha5);
        #1 chk(32'ha5, {24'h0, busy});
        #1 chk(32'ha5, {24'h0, run_bits});
        ENG.level(8'h01, 8'h02);
        wr(`QDST_CONTROL_ADDR, 32'h0);
        repeat (3) @(posedge i_clock);
        #1 chk(32'h3, {24'h0, busy});
        rd(`QDST_STATUS_ADDR, 32'h11);
        ENG.level(8'h0, 8'h0);
        repeat (3) @(posedge i_clock);
        #1 chk(32'h0, {24'h0, busy});
        wr(`QDST_IRQ_ENABLE_ADDR, 32'h1);
        rd(`QDST_IRQ_ENABLE_ADDR, 32'h1);
        // Only the timed mode may raise the request and underflow flags
        for (int m = 0; m < 4; m++)
        begin
            @(posedge i_clock);
            i_mode <= {8{m[1:0]}};
            fork
                ENG.pulse(0, 8'hff);
                begin @(posedge i_clock); ENG.pulse(1, 8'hff); end
                begin repeat (2) @(posedge i_clock);
                    rd(`QDST_STATUS_ADDR, (m == 2) ? 32'hcccc_cccc : 32'h0); end
            join
            #1 chk(32'h1, {31'h0, o_irq});
            rd(`QDST_IRQ_STATUS_ADDR, 32'h01);
            wr(`QDST_STATUS_ADDR, 32'h0);
            wr(`QDST_STATUS_ADDR, 32'h3333_3333);
            rd(`QDST_STATUS_ADDR, (m == 2) ? 32'hcccc_cccc : 32'h0);
            wr(`QDST_STATUS_ADDR, 32'h4444_4444);
            rd(`QDST_STATUS_ADDR, (m == 2) ? 32'h8888_8888 : 32'h0);
            wr(`QDST_STATUS_ADDR, 32'hffff_ffff);
            wr(`QDST_IRQ_CLEAR_ADDR, 32'hff);
            rd(`QDST_STATUS_ADDR, 32'h0);
            #1 chk(32'h0, {31'h0, o_irq});
        end
        // Timed mode: a fetch with no request pending stays quiet
        @(posedge i_clock);
        i_mode <= 16'haaaa;
        ENG.pulse(1, 8'hff);
        rd(`QDST_STATUS_ADDR, 32'h0);
        // Request and its clear in one cycle: the request wins
        fork
            ENG.pulse(0, 8'h01);
            wr(`QDST_STATUS_ADDR, 32'h4);
        join
        rd(`QDST_STATUS_ADDR, 32'h4);
        wr(`QDST_STATUS_ADDR, 32'h4);
        wr(`QDST_IRQ_CLEAR_ADDR, 32'hff);
        rd(`QDST_STATUS_ADDR, 32'h0);
        // Settle must still read one in its last cycle and zero one cycle later
        fork
            ENG.pulse(2, 8'h01);
            begin
                @(posedge i_clock);
                rd(`QDST_STATUS_ADDR, 32'h2);
                repeat (SETTLE - 3) @(posedge i_clock);
                rd(`QDST_STATUS_ADDR, 32'h2);
            end
        join
        fork
            ENG.pulse(2, 8'h01);
            begin
                repeat (SETTLE + 1) @(posedge i_clock);
                rd(`QDST_STATUS_ADDR, 32'h0);
            end
        join
        wrap_up;
    end
    // Whole run is under two hundred cycles
    initial
    begin
        #20000;
        failures++;
        wrap_up;
    end
endmodule : qdst_status_tracker_tb
